// [hw/vbc_cfg.svh]
//------------------------------------------------------------
// Purpose: Constants of the video buffer configuration bank
//------------------------------------------------------------
// Purpose: offsets, field positions, reset values, counts
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef VBC_CFG_SVH
`define VBC_CFG_SVH

// Fixed upper part of the slave address (01011)
`define VBC_ADDR_FIXED   5'h0b

// Subaddresses
`define VBC_SUB_CH1      8'h01
`define VBC_SUB_CH3      8'h03
`define VBC_SUB_SYNC     8'h04

// Channel register fields
`define VBC_BIT_CLAMP    7
`define VBC_MUX_HI       6
`define VBC_MUX_LO       3
`define VBC_MODE_HI      2
`define VBC_MODE_LO      0
`define VBC_MUX_LAST_A   4'h4
`define VBC_MUX_LAST_B   4'h9

// Channel mode codes
`define VBC_MODE_OFF     3'h0
`define VBC_MODE_MUTE    3'h1
`define VBC_MODE_DC      3'h2
`define VBC_MODE_DCSH    3'h3
`define VBC_MODE_ACB     3'h4
`define VBC_MODE_TIPL    3'h5
`define VBC_MODE_TIPM    3'h6
`define VBC_MODE_TIPH    3'h7

// Sync and master register fields
`define VBC_BIT_MON_EN   6
`define VBC_BIT_BUF_EN   5

// Power-up contents
`define VBC_PU_OFF       8'h00
`define VBC_PU_CH_ON     8'h04
`define VBC_PU_SYNC_ON   8'h40

// Serial framing counts
`define VBC_BIT_DIR      0
`define VBC_BYTE_BITS    4'h8
`define VBC_ACK_BITS     4'h9
`define VBC_INIT_WAIT    2'h3

// Synchroniser contents after reset: idle bus, low straps
`define VBC_PINS_IDLE    5'h18

`endif

// [hw/vbc_pkg.sv]
//------------------------------------------------------------
// Purpose: Types of the video buffer configuration bank
//------------------------------------------------------------
// Purpose: shared enums and structs
// Assumes: numbers live in vbc_cfg.svh
// Notes:   nothing imported; use vbc_pkg::name
package vbc_pkg;

	// Decoded channel input mode
	typedef enum logic [2:0] {
		mode_off, mode_mute, mode_dc, mode_dc_shift,
		mode_ac_bias, mode_tip_low, mode_tip_mid, mode_tip_high
	} vbc_mode_t;

	// Serial slave states
	typedef enum logic [2:0] {
		st_idle, st_addr, st_sub, st_data, st_rack, st_read, st_done
	} vbc_state_t;

	// Per-channel analog controls
	typedef struct packed {
		logic      clamp_wide;
		logic      mux_b;
		logic      mux_reserved;
		logic      monitor_en;
		logic      buffer_en;
		logic      mute;
		vbc_mode_t mode;
	} vbc_chan_ctl_t;

	// Pins from outside the clock domain
	typedef struct packed {
		logic scl;
		logic sda;
		logic strap_hi;
		logic strap_lo;
		logic pu_sel;
	} vbc_pins_t;

endpackage : vbc_pkg

// [hw/vbc_pin_sync.sv]
//------------------------------------------------------------
// Purpose: Two-stage synchroniser for the external pins
//------------------------------------------------------------
// Purpose: bring pin levels into the clk domain
// Assumes: pins are levels, no pulse shorter than two clocks
// Notes:   first stage read only by the second
`timescale 1ns/1ns
`include "vbc_cfg.svh"
module vbc_pin_sync (
	// System
	input  wire logic              clk,
	input  wire logic              reset_n,
	// Pins
	input  vbc_pkg::vbc_pins_t     pins_raw,
	output vbc_pkg::vbc_pins_t     pins
);

	vbc_pkg::vbc_pins_t meta;

	// Two flops; idle bus and low straps after reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta <= vbc_pkg::vbc_pins_t'(`VBC_PINS_IDLE);
			pins <= vbc_pkg::vbc_pins_t'(`VBC_PINS_IDLE);
		end else begin
			meta <= pins_raw;
			pins <= meta;
		end
	end

endmodule : vbc_pin_sync

// [hw/vbc_chan_decode.sv]
//------------------------------------------------------------
// Purpose: Decoder of one channel configuration byte
//------------------------------------------------------------
// Purpose: turn a channel byte into analog controls
// Assumes: master enables come from the sync register
// Notes:   outputs registered, one clock behind the byte
`timescale 1ns/1ns
`include "vbc_cfg.svh"
module vbc_chan_decode (
	// System
	input  wire logic              clk,
	input  wire logic              reset_n,
	// Configuration
	input  wire logic [7:0]        cfg,
	input  wire logic              master_mon_en,
	input  wire logic              master_buf_en,
	// Controls
	output vbc_pkg::vbc_chan_ctl_t ctl
);

	vbc_pkg::vbc_chan_ctl_t next_ctl;
	logic [3:0]             mux_code;
	logic                   tip;

	// Field decode of the byte
	always_comb begin
		mux_code = cfg[`VBC_MUX_HI:`VBC_MUX_LO];
		next_ctl = '0;
		case (cfg[`VBC_MODE_HI:`VBC_MODE_LO])
			`VBC_MODE_OFF:  next_ctl.mode = vbc_pkg::mode_off;
			`VBC_MODE_MUTE: next_ctl.mode = vbc_pkg::mode_mute;
			`VBC_MODE_DC:   next_ctl.mode = vbc_pkg::mode_dc;
			`VBC_MODE_DCSH: next_ctl.mode = vbc_pkg::mode_dc_shift;
			`VBC_MODE_ACB:  next_ctl.mode = vbc_pkg::mode_ac_bias;
			`VBC_MODE_TIPL: next_ctl.mode = vbc_pkg::mode_tip_low;
			`VBC_MODE_TIPM: next_ctl.mode = vbc_pkg::mode_tip_mid;
			default:        next_ctl.mode = vbc_pkg::mode_tip_high;
		endcase
		tip = cfg[`VBC_MODE_HI] && (cfg[`VBC_MODE_HI-1:`VBC_MODE_LO] != 2'h0);
		next_ctl.clamp_wide = cfg[`VBC_BIT_CLAMP] && tip;
		next_ctl.mux_b = (mux_code > `VBC_MUX_LAST_A) && (mux_code <= `VBC_MUX_LAST_B);
		next_ctl.mux_reserved = mux_code > `VBC_MUX_LAST_B;
		next_ctl.mute = cfg[`VBC_MODE_HI:`VBC_MODE_LO] == `VBC_MODE_MUTE;
		next_ctl.monitor_en = (cfg[`VBC_MODE_HI:`VBC_MODE_LO] != `VBC_MODE_OFF) && master_mon_en;
		next_ctl.buffer_en = (cfg[`VBC_MODE_HI:`VBC_MODE_LO] != `VBC_MODE_OFF) && master_buf_en;
	end

	// Output register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctl <= '0;
		end else begin
			ctl <= next_ctl;
		end
	end

endmodule : vbc_chan_decode

// [hw/vbc_i2c_cfg_regs.sv]
//------------------------------------------------------------
// Purpose: Serial configuration register bank
//------------------------------------------------------------
// Purpose: two-wire slave with four configuration bytes
// Assumes: clk well above the serial clock rate
// Notes:   pins sampled by clk; serial clock is not a clock
// Notes:   writes land at the stop, never at the data acknowledge
`timescale 1ns/1ns
`include "vbc_cfg.svh"

// Summary of operation
// - Answer only address bytes whose top five bits are 01011.
// - Address bits two and one follow the strap pins live, never latched.
// - First byte after a start is the address, direction in bit zero.
// - A write carries one data byte to one subaddress; no bursts.
// - A read returns the selected subaddress register as one byte.
// - Power-up select low: all registers start fully disabled.
// - Power-up select high: buffers off, monitors on, ac-bias on all channels.
// - Power-up contents hold until the first complete valid write.
// - Subaddresses 1 to 3 are channels, 4 is sync and master disable.
// - Channel bit 7 picks the narrow or wide clamp filter.
// - Clamp filter choice matters only in ac tip clamp modes.
// - Bits 6 to 3 pick mux input A, input B or reserved.
// - Mode 000 turns both paths off; 001 mutes the channel.
// - Mode 010 is dc, 011 dc with shift, 100 ac-bias.
// - Modes 101, 110, 111 are tip clamp with low, mid, high bias.
// - Writing one channel leaves the other channels untouched.
// - Write is start, address, subaddress, data, stop; each byte acked.
// - Master monitor and buffer enables in register 4 override channels.
module vbc_i2c_cfg_regs (
	// System
	input  wire logic                         clk,
	input  wire logic                         reset_n,
	// Serial bus
	input  wire logic                         scl_in,
	input  wire logic                         sda_in,
	output logic                              sda_out,
	output logic                              sda_oe,
	// Straps
	input  wire logic                         addr_strap_hi,
	input  wire logic                         addr_strap_lo,
	input  wire logic                         power_up_state_select,
	// Channel controls
	output vbc_pkg::vbc_chan_ctl_t [2:0]      chan_ctl,
	output logic [7:0]                        sync_ctl,
	// Status
	output logic                              powerup_held
);

	//------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------
	vbc_pkg::vbc_pins_t  pins_raw;
	vbc_pkg::vbc_pins_t  pins;
	vbc_pkg::vbc_state_t state;
	logic                scl_d;
	logic                sda_d;
	logic                scl_rise;
	logic                scl_fall;
	logic                start_cond;
	logic                stop_cond;
	logic [3:0]          bit_cnt;
	logic [7:0]          shreg;
	logic                drive;
	logic                byte_end;
	logic                ack_end;
	logic                addr_match;
	logic [7:0]          sub_sel;
	logic [7:0]          wdata;
	logic                wr_pend;
	logic                commit;
	logic [7:0]          rd_value;
	logic [2:0][7:0]     chan_cfg;
	logic [1:0]          init_cnt;
	logic                init_done;

	//------------------------------------------------------------
	// Functions
	//------------------------------------------------------------

	// Subaddress decode
	function automatic logic is_chan(input logic [7:0] sub);
		is_chan = (sub >= `VBC_SUB_CH1) && (sub <= `VBC_SUB_CH3);
	endfunction : is_chan

	// Index of a channel subaddress
	function automatic logic [1:0] chan_idx(input logic [7:0] sub);
		logic [7:0] diff;
		diff = sub - `VBC_SUB_CH1;
		chan_idx = diff[1:0];
	endfunction : chan_idx

	//------------------------------------------------------------
	// Pin synchronisation and bus events
	//------------------------------------------------------------

	// Gather pins
	assign pins_raw.scl      = scl_in;
	assign pins_raw.sda      = sda_in;
	assign pins_raw.strap_hi = addr_strap_hi;
	assign pins_raw.strap_lo = addr_strap_lo;
	assign pins_raw.pu_sel   = power_up_state_select;

	vbc_pin_sync u_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.pins_raw (pins_raw),
		.pins     (pins)
	);

	// Previous synchronised levels
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= pins.scl;
			sda_d <= pins.sda;
		end
	end

	// Edges, start and stop
	assign scl_rise   = pins.scl && !scl_d;
	assign scl_fall   = !pins.scl && scl_d;
	assign start_cond = pins.scl && scl_d && sda_d && !pins.sda;
	assign stop_cond  = pins.scl && scl_d && !sda_d && pins.sda;
	assign byte_end   = scl_fall && (bit_cnt == `VBC_BYTE_BITS);
	assign ack_end    = scl_fall && (bit_cnt == `VBC_ACK_BITS);

	// Address compare against live straps
	assign addr_match = shreg[7:1] == {`VBC_ADDR_FIXED, pins.strap_hi, pins.strap_lo};

	// Open-drain data pin: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe  = drive;

	//------------------------------------------------------------
	// Serial protocol
	//------------------------------------------------------------

	// Bit counter per nine-clock byte slot
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt <= 4'h0;
		end else if (start_cond || stop_cond) begin
			bit_cnt <= 4'h0;
		end else if (ack_end) begin
			bit_cnt <= 4'h0;
		end else if (scl_rise && state != vbc_pkg::st_idle) begin
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	// Shift register: in on rise, out on fall
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shreg <= 8'h00;
		end else if (state == vbc_pkg::st_rack && ack_end) begin
			shreg <= rd_value;
		end else if (state == vbc_pkg::st_read) begin
			if (scl_fall && bit_cnt != 4'h0 && bit_cnt < `VBC_BYTE_BITS) begin
				shreg <= {shreg[6:0], 1'b0};
			end
		end else if (scl_rise && bit_cnt < `VBC_BYTE_BITS) begin
			shreg <= {shreg[6:0], pins.sda};
		end
	end

	// Slave state machine
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= vbc_pkg::st_idle;
		end else if (start_cond) begin
			state <= vbc_pkg::st_addr;
		end else if (stop_cond) begin
			state <= vbc_pkg::st_idle;
		end else if (byte_end) begin
			case (state)
				vbc_pkg::st_addr: begin
					if (!addr_match) begin
						state <= vbc_pkg::st_done;
					end else if (shreg[`VBC_BIT_DIR]) begin
						state <= vbc_pkg::st_rack;
					end else begin
						state <= vbc_pkg::st_sub;
					end
				end
				vbc_pkg::st_sub:  state <= vbc_pkg::st_data;
				vbc_pkg::st_data: state <= vbc_pkg::st_done;
				vbc_pkg::st_read: state <= vbc_pkg::st_done;
				default:          state <= state;
			endcase
		end else if (ack_end && state == vbc_pkg::st_rack) begin
			state <= vbc_pkg::st_read;
		end
	end

	// Data pin drive: acks and read bits
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			drive <= 1'b0;
		end else if (start_cond || stop_cond) begin
			drive <= 1'b0;
		end else if (byte_end) begin
			case (state)
				vbc_pkg::st_addr: drive <= addr_match;
				vbc_pkg::st_sub:  drive <= 1'b1;
				vbc_pkg::st_data: drive <= 1'b1;
				default:          drive <= 1'b0;
			endcase
		end else if (ack_end) begin
			if (state == vbc_pkg::st_rack) begin
				drive <= !rd_value[7];
			end else begin
				drive <= 1'b0;
			end
		end else if (state == vbc_pkg::st_read && scl_fall && bit_cnt != 4'h0) begin
			// Next read bit sits in bit six before the shift
			drive <= !shreg[6];
		end
	end

	//------------------------------------------------------------
	// Subaddress and pending write
	//------------------------------------------------------------

	// Selected subaddress, kept across transactions
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sub_sel <= 8'h00;
		end else if (byte_end && state == vbc_pkg::st_sub) begin
			sub_sel <= shreg;
		end
	end

	// Data byte waits for the stop before it lands
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wdata   <= 8'h00;
			wr_pend <= 1'b0;
		end else if (start_cond || stop_cond) begin
			wr_pend <= 1'b0;
		end else if (byte_end && state == vbc_pkg::st_data) begin
			wdata   <= shreg;
			wr_pend <= 1'b1;
			// A further whole byte after the data byte cancels the write
		end else if (byte_end && state == vbc_pkg::st_done) begin
			wr_pend <= 1'b0;
		end
	end

	// Only a complete single-byte write commits
	assign commit = stop_cond && wr_pend && init_done;

	//------------------------------------------------------------
	// Power-up selection
	//------------------------------------------------------------

	// Wait for synchronised strap before loading
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			init_cnt  <= 2'h0;
			init_done <= 1'b0;
		end else if (!init_done) begin
			init_cnt  <= init_cnt + 2'h1;
			init_done <= init_cnt == `VBC_INIT_WAIT;
		end
	end

	//------------------------------------------------------------
	// Register file
	//------------------------------------------------------------

	// Channel registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			chan_cfg <= {3{`VBC_PU_OFF}};
		end else if (!init_done) begin
			// Strap value taken only once the synchroniser has settled
			if (init_cnt == `VBC_INIT_WAIT && pins.pu_sel) begin
				chan_cfg <= {3{`VBC_PU_CH_ON}};
			end else begin
				chan_cfg <= {3{`VBC_PU_OFF}};
			end
		end else if (commit && is_chan(sub_sel)) begin
			chan_cfg[chan_idx(sub_sel)] <= wdata;
		end
	end

	// Sync and master disable register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_ctl <= `VBC_PU_OFF;
		end else if (!init_done) begin
			if (init_cnt == `VBC_INIT_WAIT && pins.pu_sel) begin
				sync_ctl <= `VBC_PU_SYNC_ON;
			end else begin
				sync_ctl <= `VBC_PU_OFF;
			end
		end else if (commit && sub_sel == `VBC_SUB_SYNC) begin
			sync_ctl <= wdata;
		end
	end

	// Power-up contents still in force
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			powerup_held <= 1'b1;
		end else if (commit) begin
			powerup_held <= 1'b0;
		end
	end

	// Read value of the selected subaddress
	always_comb begin
		if (is_chan(sub_sel)) begin
			rd_value = chan_cfg[chan_idx(sub_sel)];
		end else if (sub_sel == `VBC_SUB_SYNC) begin
			rd_value = sync_ctl;
		end else begin
			rd_value = 8'h00;
		end
	end

	//------------------------------------------------------------
	// Channel decode
	//------------------------------------------------------------

	// One decoder per analog channel
	for (genvar ch = 0; ch < 3; ch++) begin : g_chan
		vbc_chan_decode u_dec (
			.clk           (clk),
			.reset_n       (reset_n),
			.cfg           (chan_cfg[ch]),
			.master_mon_en (sync_ctl[`VBC_BIT_MON_EN]),
			.master_buf_en (sync_ctl[`VBC_BIT_BUF_EN]),
			.ctl           (chan_ctl[ch])
		);
	end

endmodule : vbc_i2c_cfg_regs

// [dv/vbc_i2c_master_model.sv]
//--------------------
// Purpose: Two-wire bus master model
//--------------------
// Assumes: 125 ns bit period, open-drain data line with pull-up
// Notes:   both lines stand high between frames
`timescale 1ns/1ns
module vbc_i2c_master_model (
	// Bus lines
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda_wire
);
	// Idle bus, both lines released
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// One bit; data moves only while the clock is low
	task automatic xfer(input logic b, output logic r);
		scl = 1'b0;
		#30 sda_drv = b;
		#32 scl = 1'b1;
		#31 r = sda_wire;
		#32;
	endtask : xfer

	// Start when p is 1, stop when p is 0: data flips while clock high
	task automatic cond(input logic p);
		scl = 1'b0;
		#30 sda_drv = p;
		#32 scl = 1'b1;
		#31 sda_drv = !p;
		#32;
	endtask : cond

	// Byte MSB first, then the acknowledge slot with data released
	task automatic send(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			xfer(b[i], r);
		xfer(1'b1, r);
		ack = !r;
	endtask : send

	// One subaddress per transaction, n data bytes
	task automatic wr(input logic [6:0] adr, input logic [7:0] sub, input logic [7:0] dat,
		input int n, output logic [3:0] acks);
		logic a;
		acks = 4'h0;
		cond(1'b1);
		send({adr, 1'b0}, a);
		acks[0] = a;
		send(sub, a);
		acks[1] = a;
		for (int k = 0; k < n; k++) begin
			send(dat, a);
			acks[2 + k] = a;
		end
		cond(1'b0);
	endtask : wr

	// One byte read, closed by a not-acknowledge and a stop
	task automatic rd(input logic [6:0] adr, output logic [7:0] d, output logic ack);
		logic r;
		cond(1'b1);
		send({adr, 1'b1}, ack);
		for (int i = 7; i >= 0; i--) begin
			xfer(1'b1, r);
			d[i] = r;
		end
		xfer(1'b1, r);
		cond(1'b0);
	endtask : rd
endmodule : vbc_i2c_master_model

// [dv/vbc_i2c_cfg_regs_chk.sv]
//--------------------
// Purpose: Port checker of the serial configuration bank
//--------------------
// Assumes: bound to vbc_i2c_cfg_regs
// Notes:   raw pins are seen about two clocks late inside
`timescale 1ns/1ns
module vbc_i2c_cfg_regs_chk (
	// System
	input wire logic                         clk,
	input wire logic                         reset_n,
	// Serial bus
	input wire logic                         scl_in,
	input wire logic                         sda_out,
	input wire logic                         sda_oe,
	// Controls and status
	input wire vbc_pkg::vbc_chan_ctl_t [2:0] chan_ctl,
	input wire logic [7:0]                   sync_ctl,
	input wire logic                         powerup_held
);
	logic [3:0] age;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Cycles since reset, saturating; masks the strap load
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			age <= 4'h0;
		else if (age != 4'hf)
			age <= age + 4'h1;
	end

	// Bus timing of the data line driver, reset state and power-up hold
	a_open_drain: assert property (sda_out == 1'b0)
		else $error("sda_out not zero");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("sda_oe moved while scl high");
	a_oe_after_fall: assert property ($rose(sda_oe) |-> !scl_in && $past(scl_in, 6))
		else $error("sda_oe rose away from an scl fall");
	a_reset_state: assert property ($rose(reset_n) |-> powerup_held && chan_ctl == '0)
		else $error("wrong state after reset");
	a_held_commit: assert property (age == 4'hf && $changed(chan_ctl) |-> ##[0:1] !powerup_held)
		else $error("controls moved while power-up state held");

	// Decode of each channel
	for (genvar i = 0; i < 3; i++) begin : g_ch
		a_off_paths: assert property (chan_ctl[i].mode == vbc_pkg::mode_off |->
			!chan_ctl[i].monitor_en && !chan_ctl[i].buffer_en) else $error("off mode path on");
		a_mute_flag: assert property (chan_ctl[i].mute == (chan_ctl[i].mode == vbc_pkg::mode_mute))
			else $error("mute flag wrong");
		a_clamp_mode: assert property (chan_ctl[i].clamp_wide |-> chan_ctl[i].mode >= vbc_pkg::mode_tip_low)
			else $error("clamp outside tip modes");
		a_mux_excl: assert property (!(chan_ctl[i].mux_b && chan_ctl[i].mux_reserved))
			else $error("mux b and reserved both set");
		a_mon_master: assert property (chan_ctl[i].monitor_en |-> sync_ctl[6] || $past(sync_ctl[6]))
			else $error("monitor on with master off");
		a_buf_master: assert property (chan_ctl[i].buffer_en |-> sync_ctl[5] || $past(sync_ctl[5]))
			else $error("buffer on with master off");
	end
endmodule : vbc_i2c_cfg_regs_chk

bind vbc_i2c_cfg_regs vbc_i2c_cfg_regs_chk u_chk (.clk(clk), .reset_n(reset_n), .scl_in(scl_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .chan_ctl(chan_ctl), .sync_ctl(sync_ctl),
	.powerup_held(powerup_held));

// [dv/testbench.sv]
//--------------------
// Purpose: Self-checking bench of the serial configuration bank
//--------------------
// Assumes: master model drives the bus, bench drives straps and reset
// Notes:   expectations come from a byte model of the four registers
`timescale 1ns/1ns
module testbench;
	logic                         clk, reset_n, scl, sda_drv, sda_wire, sda_out, sda_oe;
	logic                         strap_hi, strap_lo, pu_sel, powerup_held, ack;
	vbc_pkg::vbc_chan_ctl_t [2:0] chan_ctl;
	logic [7:0]                   sync_ctl, d, rv;
	logic [7:0]                   regs [0:4];
	logic [3:0]                   acks;
	logic [3:0]                   mc [0:3] = '{4'h4, 4'h5, 4'h9, 4'ha};
	int                           n_mismatch, checks_done, seed;

	// Open-drain data wire with pull-up
	assign sda_wire = sda_oe ? 1'b0 : sda_drv;

	vbc_i2c_cfg_regs u_vbc_i2c_cfg_regs (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_hi(strap_hi), .addr_strap_lo(strap_lo),
		.power_up_state_select(pu_sel), .chan_ctl(chan_ctl), .sync_ctl(sync_ctl),
		.powerup_held(powerup_held));
	vbc_i2c_master_model u_vbc_i2c_master_model (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));

	// System clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Expected controls of one channel from its byte and the master byte
	function automatic vbc_pkg::vbc_chan_ctl_t exp_ctl(input logic [7:0] c, input logic [7:0] s);
		vbc_pkg::vbc_chan_ctl_t e;
		e.mode = vbc_pkg::vbc_mode_t'(c[2:0]);
		e.clamp_wide = c[7] && c[2:0] >= 3'h5;
		e.mux_b = c[6:3] >= 4'h5 && c[6:3] <= 4'h9;
		e.mux_reserved = c[6:3] >= 4'ha;
		e.mute = c[2:0] == 3'h1;
		e.monitor_en = c[2:0] != 3'h0 && s[6];
		e.buffer_en = c[2:0] != 3'h0 && s[5];
		return e;
	endfunction : exp_ctl

	// Address the device answers to with the present straps
	function automatic logic [6:0] adr();
		return {5'h0b, strap_hi, strap_lo};
	endfunction : adr

	// Compare and count
	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// All decoded controls against the register model
	task automatic chk_all();
		repeat (8) @(posedge clk);
		#1;
		for (int c = 0; c < 3; c++)
			chk("chan_ctl", exp_ctl(regs[c + 1], regs[4]), chan_ctl[c]);
		chk("sync_ctl", {1'b0, regs[4]}, {1'b0, sync_ctl});
	endtask : chk_all

	// One write, decode check, read back
	task automatic wr_chk(input logic [7:0] sub, input logic [7:0] dat);
		logic [2:0] ix;
		ix = (sub >= 8'h01 && sub <= 8'h04) ? sub[2:0] : 3'h0;
		u_vbc_i2c_master_model.wr(adr(), sub, dat, 1, acks);
		chk("write acks", 9'h007, {6'h0, acks[2:0]});
		if (ix != 3'h0)
			regs[ix] = dat;
		chk_all();
		u_vbc_i2c_master_model.rd(adr(), d, ack);
		chk("read data", {1'b0, regs[ix]}, {ack, d} ^ 9'h100);
	endtask : wr_chk

	// Reset with a chosen power-up select
	task automatic do_reset(input logic sel);
		@(posedge clk);
		#1 reset_n = 1'b0;
		pu_sel = sel;
		repeat (16) @(posedge clk);
		#1 reset_n = 1'b1;
		repeat (20) @(posedge clk);
		#1;
	endtask : do_reset

	// Verdict
	task automatic results();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	// Hang guard
	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		results();
	end

	// Main sequence
	initial begin
		seed = 22068;
		reset_n = 1'b0;
		strap_hi = 1'b0;
		strap_lo = 1'b0;
		pu_sel = 1'b1;
		regs = '{8'h00, 8'h04, 8'h04, 8'h04, 8'h40};
		do_reset(1'b1);
		chk_all();
		chk("powerup_held", 9'h001, {8'h0, powerup_held});
		u_vbc_i2c_master_model.wr(adr(), 8'h02, 8'h00, 0, acks);
		u_vbc_i2c_master_model.rd(adr(), d, ack);
		chk("select read", 9'h004, {1'b0, d});
		chk("powerup_held", 9'h001, {8'h0, powerup_held});
		u_vbc_i2c_master_model.wr({5'h0a, 2'b00}, 8'h01, 8'h55, 1, acks);
		chk("foreign ack", 9'h000, {8'h0, acks[0]});
		@(posedge clk);
		#1 strap_hi = 1'b1;
		u_vbc_i2c_master_model.wr({5'h0b, 2'b00}, 8'h01, 8'h55, 1, acks);
		chk("stale ack", 9'h000, {8'h0, acks[0]});
		chk_all();
		wr_chk(8'h04, 8'h61);
		chk("powerup_held", 9'h000, {8'h0, powerup_held});
		for (int m = 0; m < 8; m++)
			wr_chk(8'h01, {1'b1, 4'h0, 3'(m)});
		@(posedge clk);
		#1 strap_lo = 1'b1;
		for (int k = 0; k < 4; k++)
			wr_chk(8'h02, {1'b0, mc[k], 3'h5});
		repeat (12) begin
			rv = 8'($random(seed));
			wr_chk(8'h01 + 8'($unsigned($random(seed)) % 3), rv);
		end
		wr_chk(8'h00, 8'h3c);
		wr_chk(8'h05, 8'hc3);
		wr_chk(8'h04, 8'h00);
		u_vbc_i2c_master_model.wr(adr(), 8'h03, 8'h2a, 2, acks);
		chk("burst acks", 9'h007, {5'h0, acks});
		chk_all();
		regs = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		do_reset(1'b0);
		chk_all();
		chk("powerup_held", 9'h001, {8'h0, powerup_held});
		results();
	end
endmodule : testbench
